// ### shared/eemseq_pkg.sv
// Constants and types shared by the memory-controller sequencer
`default_nettype none
package eemseq_pkg;
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam int PAGE_BYTES = 16;
  localparam int PAGE_LSB = 4;
  localparam int CLK_PERIOD_NS = 10;
  // Access time of the device in a read
  localparam int ACCESS_NS = 300;
  localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Strobe low time for load, page erase, write and chip erase
  localparam int PULSE_NS = 200;
  localparam int PULSE_CYC = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Recovery between load strobes
  localparam int RECOV_NS = 100;
  localparam int RECOV_CYC = (RECOV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Control setup after load or read
  localparam int SETUP_NS = 500;
  localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Busy wait after erase or write: worst erase 200 ms plus setup 50 us
  localparam int ERASE_MS = 200;
  localparam int NV_SETUP_US = 50;
  localparam int NV_WAIT_CYC =
    (ERASE_MS * 1000000 + NV_SETUP_US * 1000) / CLK_PERIOD_NS;
  localparam int CNT_W = 25;
  localparam logic [CNT_W-1:0] CNT_ZERO = 25'h0000000;
  localparam logic [CNT_W-1:0] CNT_ONE = 25'h0000001;
  localparam logic [3:0] IDX_ZERO = 4'h0;
  localparam logic [3:0] IDX_ONE = 4'h1;
  localparam logic [3:0] IDX_LAST = 4'hF;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 13'h0000;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
  localparam logic [DATA_W-1:0] DATA_ERASED = 8'h00;
  typedef enum logic [2:0] {
    EEMSEQ_CMD_READ = 3'h0,
    EEMSEQ_CMD_CHIP_ERASE = 3'h1,
    EEMSEQ_CMD_PAGE_ERASE = 3'h2,
    EEMSEQ_CMD_PAGE_WRITE = 3'h3
  } eemseq_cmd_e;
endpackage
`default_nettype wire

// ### core/eemseq_buf.sv
// Sixteen-byte staging memory for page write data
`default_nettype none
module eemseq_buf
  import eemseq_pkg::*;
(
  input wire logic clk,
  input wire logic we,
  input wire logic [3:0] waddr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [3:0] raddr,
  output logic [DATA_W-1:0] rdata_q
);
  logic [DATA_W-1:0] mem [PAGE_BYTES];
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_q <= mem[raddr];
  end
endmodule // eemseq_buf
`default_nettype wire

// ### core/eemseq_host.sv
// Host sequencer driving the parallel pins of the erasable memory
`default_nettype none
// Overview of operation
// - Chip erase: mode1 high, mode2 low, then select and output enable low.
// - Page erase: mode1 high, mode2 low, select and write enable low.
// - Address and data stay stable while select and write enable are low.
// - Load bytes are always followed by a write before any other mode.
// - One to sixteen bytes are loaded then written in one operation.
// - Write: mode2 high, mode1 low, then select and write enable low.
module eemseq_host
  import eemseq_pkg::*;
#(
  parameter int NV_WAIT = NV_WAIT_CYC
) (
  input wire logic SYS_CLK,
  input wire logic SRST,
  input wire logic CMD_VALID,
  input wire eemseq_pkg::eemseq_cmd_e CMD_OP,
  input wire logic [eemseq_pkg::ADDR_W-1:0] CMD_ADDR,
  input wire logic [3:0] CMD_LEN_M1,
  input wire logic WR_VALID,
  input wire logic [eemseq_pkg::DATA_W-1:0] WR_DATA,
  output logic CMD_READY,
  output logic WR_READY,
  output logic RD_VALID,
  output logic [eemseq_pkg::DATA_W-1:0] RD_DATA,
  output logic BUSY,
  output logic [eemseq_pkg::ADDR_W-1:0] MEM_ADDR,
  output logic [eemseq_pkg::DATA_W-1:0] MEM_DQ_OUT,
  output logic MEM_DQ_OE,
  input wire logic [eemseq_pkg::DATA_W-1:0] MEM_DQ_IN,
  output logic MEM_SEL_N,
  output logic MEM_OUT_EN_N,
  output logic MEM_WR_EN_N,
  output logic MODE_CONTROL_1,
  output logic MODE_CONTROL_2
);
  import eemseq_pkg::*;

  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_FILL = 4'h1,
    S_RD_WAIT = 4'h2,
    S_RD_DONE = 4'h3,
    S_LD_SET = 4'h4,
    S_LD_LOW = 4'h5,
    S_LD_HIGH = 4'h6,
    S_NV_SET = 4'h7,
    S_NV_LOW = 4'h8,
    S_NV_WAIT = 4'h9,
    S_SETTLE = 4'hA
  } eemseq_state_e;

  function automatic logic [CNT_W-1:0] cyc(input int n);
    cyc = n[CNT_W-1:0];
  endfunction

  eemseq_state_e state_q, state_d;
  eemseq_cmd_e op_q;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [ADDR_W-1:0] base_q;
  logic [3:0] len_q, idx_q, idx_d;
  logic [DATA_W-1:0] din_s1_q, din_s2_q, buf_rd;
  logic cmd_ready_q, wr_ready_q, rd_valid_q, busy_q;
  logic [DATA_W-1:0] rd_data_q, dq_out_q;
  logic dq_oe_q, sel_n_q, oe_n_q, we_n_q, mc1_q, mc2_q;
  logic [ADDR_W-1:0] addr_q;

  wire logic cnt_done = (cnt_q == CNT_ZERO);
  wire logic cmd_take = cmd_ready_q && CMD_VALID;
  wire logic wr_take = wr_ready_q && WR_VALID;
  wire logic is_write_cmd = (CMD_OP == EEMSEQ_CMD_PAGE_WRITE);
  wire logic fill_last = wr_take && (idx_q == len_q);
  wire logic load_last = (idx_q == len_q);
  // Byte address inside a page follows the load index
  wire logic [ADDR_W-1:0] load_addr = {base_q[ADDR_W-1:PAGE_LSB], idx_q};
  wire logic [3:0] buf_raddr = (state_q == S_LD_HIGH) ? idx_q + IDX_ONE
                                                      : idx_q;

  eemseq_buf u_buf (
    .clk(SYS_CLK),
    .we(wr_take),
    .waddr(idx_q),
    .wdata(WR_DATA),
    .raddr(buf_raddr),
    .rdata_q(buf_rd)
  );

  // Pin data passes two flops before it is read
  always_ff @(posedge SYS_CLK) begin
    din_s1_q <= MEM_DQ_IN;
    din_s2_q <= din_s1_q;
  end

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_done ? CNT_ZERO : cnt_q - CNT_ONE;
    idx_d = idx_q;
    case (state_q)
      S_IDLE: begin
        if (cmd_take) begin
          idx_d = IDX_ZERO;
          case (CMD_OP)
            EEMSEQ_CMD_READ: begin
              state_d = S_RD_WAIT;
              cnt_d = cyc(ACCESS_CYC + 2);
            end
            EEMSEQ_CMD_PAGE_WRITE: state_d = S_FILL;
            default: begin
              state_d = S_NV_SET;
              cnt_d = cyc(1);
            end
          endcase
        end
      end
      S_FILL: begin
        if (wr_take) begin
          idx_d = idx_q + IDX_ONE;
        end
        if (fill_last) begin
          state_d = S_LD_SET;
          idx_d = IDX_ZERO;
          cnt_d = cyc(1);
        end
      end
      S_RD_WAIT: if (cnt_done) state_d = S_RD_DONE;
      S_RD_DONE: begin
        state_d = S_SETTLE;
        cnt_d = cyc(SETUP_CYC);
      end
      S_LD_SET: begin
        if (cnt_done) begin
          state_d = S_LD_LOW;
          cnt_d = cyc(PULSE_CYC);
        end
      end
      S_LD_LOW: begin
        if (cnt_done) begin
          state_d = S_LD_HIGH;
          cnt_d = cyc(RECOV_CYC);
        end
      end
      S_LD_HIGH: begin
        if (cnt_done) begin
          if (load_last) begin
            state_d = S_NV_SET;
            cnt_d = cyc(SETUP_CYC);
          end else begin
            state_d = S_LD_LOW;
            idx_d = idx_q + IDX_ONE;
            cnt_d = cyc(PULSE_CYC);
          end
        end
      end
      S_NV_SET: begin
        if (cnt_done) begin
          state_d = S_NV_LOW;
          cnt_d = cyc(PULSE_CYC);
        end
      end
      S_NV_LOW: begin
        if (cnt_done) begin
          state_d = S_NV_WAIT;
          cnt_d = cyc(NV_WAIT);
        end
      end
      S_NV_WAIT: if (cnt_done) state_d = S_IDLE;
      S_SETTLE: if (cnt_done) state_d = S_IDLE;
      default: state_d = S_IDLE;
    endcase
  end

  // Pin levels per state; strobes only fall after modes have settled
  wire logic in_load = (state_q == S_LD_SET) || (state_q == S_LD_LOW) ||
                       (state_q == S_LD_HIGH);
  wire logic in_nv = (state_q == S_NV_SET) || (state_q == S_NV_LOW) ||
                     (state_q == S_NV_WAIT);
  wire logic in_read = (state_q == S_RD_WAIT) || (state_q == S_RD_DONE);
  wire logic nv_erase = in_nv && (op_q != EEMSEQ_CMD_PAGE_WRITE);
  wire logic nv_write = in_nv && (op_q == EEMSEQ_CMD_PAGE_WRITE);
  wire logic strobe = (state_q == S_LD_LOW) || (state_q == S_NV_LOW);
  wire logic chip_er = (op_q == EEMSEQ_CMD_CHIP_ERASE);
  wire logic mc1_d = !(in_load || nv_write);
  wire logic mc2_d = !(in_load || nv_erase);
  wire logic sel_n_d = !(in_read || strobe);
  wire logic oe_n_d = !(in_read || (strobe && nv_erase && chip_er));
  wire logic we_n_d = !(strobe && !(nv_erase && chip_er));
  wire logic [ADDR_W-1:0] addr_d = in_load ? load_addr : base_q;

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      state_q <= S_IDLE;
      cnt_q <= CNT_ZERO;
      idx_q <= IDX_ZERO;
      op_q <= EEMSEQ_CMD_READ;
      base_q <= ADDR_ZERO;
      len_q <= IDX_ZERO;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      idx_q <= idx_d;
      if (cmd_take) begin
        op_q <= CMD_OP;
        base_q <= CMD_ADDR;
        len_q <= is_write_cmd ? CMD_LEN_M1 : IDX_ZERO;
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      cmd_ready_q <= 1'b0;
      wr_ready_q <= 1'b0;
      rd_valid_q <= 1'b0;
      rd_data_q <= DATA_ZERO;
      busy_q <= 1'b0;
      addr_q <= ADDR_ZERO;
      dq_out_q <= DATA_ZERO;
      dq_oe_q <= 1'b0;
      sel_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      we_n_q <= 1'b1;
      mc1_q <= 1'b1;
      mc2_q <= 1'b1;
    end else begin
      cmd_ready_q <= (state_d == S_IDLE) && !cmd_take;
      wr_ready_q <= (state_d == S_FILL) && !fill_last;
      rd_valid_q <= (state_q == S_RD_DONE);
      if (state_q == S_RD_DONE) begin
        rd_data_q <= din_s2_q;
      end
      busy_q <= in_nv;
      addr_q <= addr_d;
      dq_out_q <= buf_rd;
      dq_oe_q <= in_load;
      sel_n_q <= sel_n_d;
      oe_n_q <= oe_n_d;
      we_n_q <= we_n_d;
      mc1_q <= mc1_d;
      mc2_q <= mc2_d;
    end
  end

  assign CMD_READY = cmd_ready_q;
  assign WR_READY = wr_ready_q;
  assign RD_VALID = rd_valid_q;
  assign RD_DATA = rd_data_q;
  assign BUSY = busy_q;
  assign MEM_ADDR = addr_q;
  assign MEM_DQ_OUT = dq_out_q;
  assign MEM_DQ_OE = dq_oe_q;
  assign MEM_SEL_N = sel_n_q;
  assign MEM_OUT_EN_N = oe_n_q;
  assign MEM_WR_EN_N = we_n_q;
  assign MODE_CONTROL_1 = mc1_q;
  assign MODE_CONTROL_2 = mc2_q;

  // Address and data must not move during a load strobe
  property p_load_stable;
    @(posedge SYS_CLK) disable iff (SRST)
    (!MEM_SEL_N && !MEM_WR_EN_N && !MODE_CONTROL_1 && !MODE_CONTROL_2 &&
     !$past(MEM_SEL_N) && !$past(MEM_WR_EN_N))
    |-> $stable(MEM_ADDR) && $stable(MEM_DQ_OUT);
  endproperty
  a_load_stable: assert property (p_load_stable)
    else $error("address or data moved during load strobe");

  property p_read_pins;
    @(posedge SYS_CLK) disable iff (SRST)
    (!MEM_SEL_N && !MEM_OUT_EN_N && MODE_CONTROL_2)
    |-> MEM_WR_EN_N && MODE_CONTROL_1 && !MEM_DQ_OE;
  endproperty
  a_read_pins: assert property (p_read_pins)
    else $error("read pin levels wrong");

  // Data is taken only after select and output enable stood low a full access
  property p_read_delay;
    @(posedge SYS_CLK) disable iff (SRST)
    $rose(RD_VALID) |-> !$past(MEM_SEL_N, 32) && !$past(MEM_OUT_EN_N, 32);
  endproperty
  a_read_delay: assert property (p_read_delay)
    else $error("read sampled too early");

  property p_chip_erase;
    @(posedge SYS_CLK) disable iff (SRST)
    !MEM_SEL_N && !MODE_CONTROL_2 && !MEM_OUT_EN_N
    |-> MODE_CONTROL_1 && MEM_WR_EN_N && $past(MODE_CONTROL_1);
  endproperty
  a_chip_erase: assert property (p_chip_erase)
    else $error("chip erase pin levels wrong");

  property p_page_erase;
    @(posedge SYS_CLK) disable iff (SRST)
    !MEM_SEL_N && !MEM_WR_EN_N && MODE_CONTROL_1 |-> !MODE_CONTROL_2 &&
    MEM_OUT_EN_N && !MEM_DQ_OE;
  endproperty
  a_page_erase: assert property (p_page_erase)
    else $error("page erase pin levels wrong");

  property p_load_pins;
    @(posedge SYS_CLK) disable iff (SRST)
    !MEM_WR_EN_N && !MODE_CONTROL_1 && !MODE_CONTROL_2
    |-> MEM_OUT_EN_N && MEM_DQ_OE && !MEM_SEL_N;
  endproperty
  a_load_pins: assert property (p_load_pins)
    else $error("load pin levels wrong");

  property p_load_then_write;
    @(posedge SYS_CLK) disable iff (SRST)
    $fell(MEM_DQ_OE) |-> MODE_CONTROL_2 && !MODE_CONTROL_1;
  endproperty
  a_load_then_write: assert property (p_load_then_write)
    else $error("load not followed by write mode");

  property p_write_pins;
    @(posedge SYS_CLK) disable iff (SRST)
    !MEM_SEL_N && MODE_CONTROL_2 && !MODE_CONTROL_1
    |-> MEM_OUT_EN_N && !MEM_WR_EN_N;
  endproperty
  a_write_pins: assert property (p_write_pins)
    else $error("write pin levels wrong");

  property p_nv_hold;
    @(posedge SYS_CLK) disable iff (SRST)
    $rose(BUSY) |-> BUSY [*8];
  endproperty
  a_nv_hold: assert property (p_nv_hold)
    else $error("busy wait cut short");

  // Between load strobes select is high but the host keeps driving data
  property p_standby;
    @(posedge SYS_CLK) disable iff (SRST)
    MEM_SEL_N && MODE_CONTROL_1 && MODE_CONTROL_2 |-> !MEM_DQ_OE;
  endproperty
  a_standby: assert property (p_standby)
    else $error("data driven while deselected");

  c_read: cover property (@(posedge SYS_CLK) RD_VALID);
  c_write: cover property (@(posedge SYS_CLK)
    !MEM_WR_EN_N && MODE_CONTROL_2 && !MODE_CONTROL_1);
  c_chip: cover property (@(posedge SYS_CLK)
    !MEM_OUT_EN_N && !MODE_CONTROL_2);
  c_page: cover property (@(posedge SYS_CLK)
    !MEM_WR_EN_N && MODE_CONTROL_1 && !MODE_CONTROL_2);
endmodule // eemseq_host
`default_nettype wire

// ### tb/eemseq_mem_model.sv
// Pin-level behavioural model of the paged erasable memory
`default_nettype none
module eemseq_mem_model #(
  parameter int OP_CYC = 40
) (
  input wire logic clk,
  input wire logic [eemseq_pkg::ADDR_W-1:0] addr,
  input wire logic [eemseq_pkg::DATA_W-1:0] dq_in,
  input wire logic sel_n,
  input wire logic out_en_n,
  input wire logic wr_en_n,
  input wire logic mc1,
  input wire logic mc2,
  output logic [eemseq_pkg::DATA_W-1:0] dq_out,
  output logic viol
);
  timeunit 1ns;
  timeprecision 1ns;
  import eemseq_pkg::*;
  localparam int ACC = ACCESS_NS / CLK_PERIOD_NS - 1;
  logic [DATA_W-1:0] mem [2**ADDR_W];
  logic [DATA_W-1:0] lat_q [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] latv_q;
  logic [ADDR_W-1:PAGE_LSB] pg_q;
  logic [ADDR_W-1:0] a_q, sa_q;
  logic [DATA_W-1:0] sd_q;
  logic lo_q, rd_q, ld_q;
  int age_q, busy_q;
  wire logic [ADDR_W-1:PAGE_LSB] pg = addr[ADDR_W-1:PAGE_LSB];
  wire logic rd = !sel_n && !out_en_n && wr_en_n && mc1 && mc2;
  wire logic lo = !sel_n && !(out_en_n && wr_en_n);
  wire logic ce = lo && !out_en_n && wr_en_n && mc1 && !mc2;
  wire logic pe = lo && out_en_n && !wr_en_n && mc1 && !mc2;
  wire logic ld = lo && out_en_n && !wr_en_n && !mc1 && !mc2;
  wire logic wr = lo && out_en_n && !wr_en_n && !mc1 && mc2;
  wire logic ok = rd && rd_q && addr == a_q;
  // Released pins show the inverse byte, so a stale sample cannot pass
  assign dq_out = (ok && age_q >= ACC) ? mem[addr] : ~mem[addr];
  initial begin
    foreach (mem[i]) mem[i] = 8'hA5;
    latv_q = '0;
    lo_q = 1'b0;
    ld_q = 1'b0;
    busy_q = 0;
    viol = 1'b0;
  end
  always @(posedge clk) begin
    viol <= 1'b0;
    rd_q <= rd;
    a_q <= addr;
    lo_q <= lo;
    age_q <= ok ? age_q + 1 : 0;
    if (busy_q != 0) busy_q <= busy_q - 1;
    if (lo && lo_q && ld_q && (addr != sa_q || dq_in != sd_q)) viol <= 1'b1;
    if (lo && !lo_q) begin
      sa_q <= addr;
      sd_q <= dq_in;
      ld_q <= ld;
      if (busy_q != 0) viol <= 1'b1;
      if (!ld && !wr && latv_q != '0) viol <= 1'b1;
      if (ld) begin
        lat_q[addr[3:0]] <= dq_in;
        latv_q[addr[3:0]] <= 1'b1;
        pg_q <= pg;
      end else begin
        latv_q <= '0;
      end
      if (ce) foreach (mem[i]) mem[i] = DATA_ERASED;
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (pe) mem[{pg, i[3:0]}] = DATA_ERASED;
        if (wr && latv_q[i]) mem[{pg_q, i[3:0]}] |= lat_q[i];
      end
      // Address and data are held inside, the pins are free meanwhile
      if (ce || pe || wr) busy_q <= OP_CYC;
    end
  end
endmodule // eemseq_mem_model
`default_nettype wire

// ### tb/eemseq_host_tb.sv
// Self-checking bench for the erasable-memory host sequencer
`default_nettype none
module eemseq_host_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import eemseq_pkg::*;
  logic SYS_CLK, SRST, CMD_VALID, WR_VALID, CMD_READY, WR_READY, RD_VALID;
  logic BUSY, MEM_DQ_OE, MEM_SEL_N, MEM_OUT_EN_N, MEM_WR_EN_N, viol;
  logic MODE_CONTROL_1, MODE_CONTROL_2;
  eemseq_cmd_e CMD_OP;
  logic [ADDR_W-1:0] CMD_ADDR, MEM_ADDR, a;
  logic [3:0] CMD_LEN_M1;
  logic [DATA_W-1:0] WR_DATA, RD_DATA, MEM_DQ_OUT, dev_dq, rs;
  logic [DATA_W-1:0] shadow [2**ADDR_W];
  logic [DATA_W-1:0] expq [$];
  int bad_count, n_compared;
  wire logic [DATA_W-1:0] dq = MEM_DQ_OE ? MEM_DQ_OUT : dev_dq;

  eemseq_host #(.NV_WAIT(50)) i_eemseq_host (
    .SYS_CLK(SYS_CLK), .SRST(SRST), .CMD_VALID(CMD_VALID),
    .CMD_OP(CMD_OP), .CMD_ADDR(CMD_ADDR), .CMD_LEN_M1(CMD_LEN_M1),
    .WR_VALID(WR_VALID), .WR_DATA(WR_DATA), .CMD_READY(CMD_READY),
    .WR_READY(WR_READY), .RD_VALID(RD_VALID), .RD_DATA(RD_DATA),
    .BUSY(BUSY), .MEM_ADDR(MEM_ADDR), .MEM_DQ_OUT(MEM_DQ_OUT),
    .MEM_DQ_OE(MEM_DQ_OE), .MEM_DQ_IN(dq), .MEM_SEL_N(MEM_SEL_N),
    .MEM_OUT_EN_N(MEM_OUT_EN_N), .MEM_WR_EN_N(MEM_WR_EN_N),
    .MODE_CONTROL_1(MODE_CONTROL_1), .MODE_CONTROL_2(MODE_CONTROL_2));

  eemseq_mem_model i_eemseq_mem_model (
    .clk(SYS_CLK), .addr(MEM_ADDR), .dq_in(dq), .sel_n(MEM_SEL_N),
    .out_en_n(MEM_OUT_EN_N), .wr_en_n(MEM_WR_EN_N),
    .mc1(MODE_CONTROL_1), .mc2(MODE_CONTROL_2), .dq_out(dev_dq),
    .viol(viol));

  initial begin
    SYS_CLK = 1'b0;
    forever #5 SYS_CLK = ~SYS_CLK;
  end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic wait_ready;
    int n;
    n = 0;
    while (CMD_READY !== 1'b1 && n < 5000) begin
      @(posedge SYS_CLK);
      n++;
    end
    if (n == 5000) chk(8'h00, 8'h01);
  endtask

  task automatic issue(input eemseq_cmd_e op, input logic [12:0] ad,
                       input logic [3:0] len);
    wait_ready;
    CMD_VALID <= 1'b1;
    CMD_OP <= op;
    CMD_ADDR <= ad;
    CMD_LEN_M1 <= len;
    @(posedge SYS_CLK);
    CMD_VALID <= 1'b0;
    @(posedge SYS_CLK);
  endtask

  task automatic rd(input logic [12:0] ad);
    expq.push_back(shadow[ad]);
    issue(EEMSEQ_CMD_READ, ad, 4'h0);
  endtask

  task automatic rd_page(input logic [12:0] ad);
    for (int k = 0; k < PAGE_BYTES; k++) rd({ad[12:4], k[3:0]});
  endtask

  task automatic wr_page(input logic [12:0] ad, input logic [3:0] len);
    int n;
    issue(EEMSEQ_CMD_PAGE_WRITE, ad, len);
    for (int k = 0; k <= len; k++) begin
      rs = lfsr(rs);
      WR_VALID <= 1'b1;
      WR_DATA <= rs;
      shadow[{ad[12:4], k[3:0]}] |= rs;
      n = 0;
      do begin
        @(posedge SYS_CLK);
        n++;
      end while (WR_READY !== 1'b1 && n < 100);
      chk({7'h00, WR_READY}, 8'h01);
    end
    WR_VALID <= 1'b0;
    @(posedge SYS_CLK);
    chk({7'h00, WR_READY}, 8'h00);
  endtask

  task automatic erase(input eemseq_cmd_e op, input logic [12:0] ad);
    issue(op, ad, 4'h0);
    repeat (4) @(posedge SYS_CLK);
    chk({7'h00, BUSY}, 8'h01);
  endtask

  // Each read result is matched against the oldest expectation
  always @(posedge SYS_CLK) begin
    if (RD_VALID === 1'b1)
      chk(RD_DATA, expq.size() > 0 ? expq.pop_front() : 8'hXX);
    if (viol === 1'b1) chk(8'h01, 8'h00);
  end

  initial begin
    repeat (40000) @(posedge SYS_CLK);
    bad_count++;
    wrap_up;
  end

  initial begin
    SRST = 1'b1;
    CMD_VALID = 1'b0;
    CMD_OP = EEMSEQ_CMD_READ;
    CMD_ADDR = 13'h0000;
    CMD_LEN_M1 = 4'h0;
    WR_VALID = 1'b0;
    WR_DATA = 8'h00;
    rs = 8'h53;
    bad_count = 0;
    n_compared = 0;
    repeat (20) @(posedge SYS_CLK);
    SRST <= 1'b0;
    wait_ready;
    chk({4'h0, MEM_SEL_N, MODE_CONTROL_1, MODE_CONTROL_2, MEM_DQ_OE},
        8'h0E);
    erase(EEMSEQ_CMD_CHIP_ERASE, 13'h1ABC);
    foreach (shadow[i]) shadow[i] = DATA_ERASED;
    for (int i = 0; i < 4; i++) begin
      rs = lfsr(rs);
      rd({rs[4:0], rs});
    end
    wr_page(13'h0040, 4'h0);
    wr_page(13'h1FF0, 4'hF);
    rs = lfsr(rs);
    a = {rs[4:0], rs};
    rs = lfsr(rs);
    wr_page(a, rs[3:0]);
    rd_page(a);
    rd_page(13'h0040);
    wr_page(13'h0040, 4'h3);
    rd_page(13'h0040);
    erase(EEMSEQ_CMD_PAGE_ERASE, 13'h1FF5);
    for (int k = 0; k < PAGE_BYTES; k++) shadow[{9'h1FF, k[3:0]}] = 8'h00;
    rd_page(13'h1FF0);
    rd_page(13'h0040);
    wait_ready;
    chk(8'(expq.size()), 8'h00);
    wrap_up;
  end
endmodule // eemseq_host_tb
`default_nettype wire
